// file: shared/timer_params.svh
// Register offsets, field positions, reset values and timing counts
// for the timer block. Assumes a byte-wide register port.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ========================================================
// Register offsets
`define OFS_TIMER_CTRL     8'h00
`define OFS_TIMER_MODE     8'h01
`define OFS_T0_LOW         8'h02
`define OFS_T0_HIGH        8'h03
`define OFS_T1_LOW         8'h04
`define OFS_T1_HIGH        8'h05
`define OFS_T2_CONTROL     8'h06
`define OFS_T2_MODE        8'h07
`define OFS_T2_COUNT_LOW   8'h08
`define OFS_T2_COUNT_HIGH  8'h09
`define OFS_T2_CAP_LOW     8'h0a
`define OFS_T2_CAP_HIGH    8'h0b
`define OFS_POWER_CONTROL  8'h0c

// ========================================================
// Field positions
`define BIT_T1_FLAG        7
`define BIT_T1_RUN         6
`define BIT_T0_FLAG        5
`define BIT_T0_RUN         4
`define BIT_T1_GATE        7
`define BIT_T1_SOURCE      6
`define BIT_T0_GATE        3
`define BIT_T0_SOURCE      2
`define BIT_T2_FLAG        7
`define BIT_T2_EXT_FLAG    6
`define BIT_U1_RX_SEL      5
`define BIT_U1_TX_SEL      4
`define BIT_T2_EXT_EN      3
`define BIT_T2_RUN         2
`define BIT_T2_SOURCE      1
`define BIT_T2_CAPTURE     0
`define BIT_T2_DOWN_EN     0
`define BIT_U2_RX_SEL      5
`define BIT_U2_TX_SEL      4

// ========================================================
// Reset values and timing
`define RESET_BYTE         8'h00
`define MACHINE_CYCLE_DIV  12
`define COUNT_MAX8         8'hff
`define COUNT_MAX16        16'hffff

`endif

// file: shared/timer_pkg.sv
// Types shared by the timer block and its bench.
// Assumes timer_params.svh for every number.
package timer_pkg;

  // ======================================================
  // Basic timer mode pairs (high, low)
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } basic_mode_e;

  // ======================================================
  // Pin group, asynchronous, sampled on clk_sys
  typedef struct packed {
    logic t2TriggerPin;
    logic t2CountPin;
    logic t1CountPin;
    logic t0CountPin;
    logic extIrq1Pin;
    logic extIrq0Pin;
  } timer_pins_s;

  // Baud clock pulses to the serial ports
  typedef struct packed {
    logic uart2Tx;
    logic uart2Rx;
    logic uart1Tx;
    logic uart1Rx;
  } baud_pulses_s;

  // ======================================================
  // All state of the timer block
  typedef struct packed {
    logic [3:0] prescale;
    timer_pins_s sync1;
    timer_pins_s sync2;
    timer_pins_s prev;
    logic [7:0] timerCtrl;
    logic [7:0] timerMode;
    logic [7:0] t0LowCount;
    logic [7:0] t0HighCount;
    logic [7:0] t1LowCount;
    logic [7:0] t1HighReload;
    logic [7:0] timer2Control;
    logic [7:0] t2ModeRegister;
    logic [7:0] t2CountLow;
    logic [7:0] t2CountHigh;
    logic [7:0] t2CaptureLow;
    logic [7:0] t2CaptureHigh;
    logic [7:0] powerControlReg;
    logic [7:0] regRdata;
    logic irqT0;
    logic irqT1;
    logic irqT2;
    baud_pulses_s baud;
  } timer_state_s;

endpackage : timer_pkg

// file: design/timer_autoreload_split_capture.sv
// Timer block: basic timers 0/1 in reload and split modes, and timer 2
// with capture, 16-bit reload, trigger pin and baud generation.
// Assumes a byte register port on clk_sys, and asynchronous pins.
//
// How it works
// [RULE_01] Reload mode: low byte counts, overflow sets flag, reloads from high byte.
// [RULE_02] Timer 1 in split mode freezes its count, as if stopped.
// [RULE_03] Timer 0 split: low byte counts under timer 0 controls, sets its flag.
// [RULE_04] Timer 0 split: high byte counts machine cycles, runs on timer 1 run bit.
// [RULE_05] Timer 0 split: timer 1 runs out of split mode, only feeds baud.
// [RULE_06] Timer 2 counts machine cycles, or falling edges of its count pin.
// [RULE_07] Capture mode is 16-bit up count; overflow sets timer 2 flag.
// [RULE_08] Capture: trigger falling edge copies count into capture, sets external flag.
// [RULE_09] Reload mode: rollover sets flag and loads count from capture registers.
// [RULE_10] Reload mode with external enable: trigger edge also reloads unless down enable set, sets flag.
// [RULE_11] Capture select picks capture; baud select forces reload on overflow.
// [RULE_12] Any of four baud selects gives baud mode; no overflow flag there.
// [RULE_13] Port 1 clocks from timer 2 when selected, otherwise from timer 1.
// [RULE_14] Port 2 selects sit in power control register, same meaning.
// [RULE_15] Baud mode trigger edge only sets external flag, no capture or reload.
// [RULE_16] External enable clear: trigger edges ignored; level still picks direction under down enable.
// [RULE_17] Timer 2 flags cleared only by software; either raises timer 2 request.
// [RULE_18] Timer 2 run bit starts counting; clear stops it in all modes.
// [RULE_19] Capture mode always counts up, down enable ignored.
// [RULE_20] Reload with down enable: trigger level picks direction, 0 down, 1 up.
// [RULE_21] Mode pair (1,0) is 8-bit reload, (1,1) is split or hold.
// [RULE_22] Gate set: count only while interrupt pin high and run bit set.
// [RULE_23] Basic timer flags set on overflow, cleared when core vectors.
`timescale 1ns/1ns

`include "timer_params.svh"

module timer_autoreload_split_capture
  import timer_pkg::*;
#(
  parameter int MACHINE_DIV = `MACHINE_CYCLE_DIV
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Pins from outside
  input wire timer_pins_s pins,
  // Vector acknowledges from the core
  input wire logic ackT0,
  input wire logic ackT1,
  // Interrupt requests
  output logic irqT0,
  output logic irqT1,
  output logic irqT2,
  // Baud clocks to the serial ports
  output baud_pulses_s baud
);

  // ======================================================
  // Elaboration checks
  // Prescaler is four bits wide, so the divider must fit it
  if (MACHINE_DIV < 2 || MACHINE_DIV > 16) begin : gen_div_check
    $error("MACHINE_DIV must lie between 2 and 16");
  end

  localparam logic [3:0] PRESCALE_LAST = 4'(MACHINE_DIV - 1);

  // ======================================================
  // Helper functions
  // Gate test shared by both basic timers
  function automatic logic gateOk(input logic run, input logic gate, input logic irqPin);
    gateOk = run && (!gate || irqPin); // RULE_22
  endfunction : gateOk

  // Register read decode
  function automatic logic [7:0] readReg(input timer_state_s st, input logic [7:0] addr);
    case (addr)
      `OFS_TIMER_CTRL: readReg = st.timerCtrl;
      `OFS_TIMER_MODE: readReg = st.timerMode;
      `OFS_T0_LOW: readReg = st.t0LowCount;
      `OFS_T0_HIGH: readReg = st.t0HighCount;
      `OFS_T1_LOW: readReg = st.t1LowCount;
      `OFS_T1_HIGH: readReg = st.t1HighReload;
      `OFS_T2_CONTROL: readReg = st.timer2Control;
      `OFS_T2_MODE: readReg = st.t2ModeRegister;
      `OFS_T2_COUNT_LOW: readReg = st.t2CountLow;
      `OFS_T2_COUNT_HIGH: readReg = st.t2CountHigh;
      `OFS_T2_CAP_LOW: readReg = st.t2CaptureLow;
      `OFS_T2_CAP_HIGH: readReg = st.t2CaptureHigh;
      `OFS_POWER_CONTROL: readReg = st.powerControlReg;
      default: readReg = `RESET_BYTE; // Unmapped reads give zero
    endcase
  endfunction : readReg

  // ======================================================
  // State
  timer_state_s s;
  timer_state_s next_s;

  // Decoded controls and events
  logic machineTick;
  timer_pins_s pinFall;
  basic_mode_e mode0;
  basic_mode_e mode1;
  logic split0;
  logic src0;
  logic src1;
  logic count0;
  logic count1;
  logic ovf0;
  logic ovfHigh0;
  logic ovf1;
  logic baudMode;
  logic captureMode;
  logic extEnable;
  logic downCount;
  logic src2;
  logic ovf2;
  logic trigEvent;
  logic [15:0] t2Count;
  logic [15:0] t2Reload;

  // ======================================================
  // Next-state logic
  always_comb begin
    next_s = s;

    // Two-flop synchronisers, third stage only for edge detect
    next_s.sync1 = pins;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    pinFall = s.prev & ~s.sync2;

    // Machine cycle prescaler
    machineTick = (s.prescale == PRESCALE_LAST);
    next_s.prescale = machineTick ? 4'h0 : s.prescale + 4'h1;

    // Basic timer mode decode
    mode0 = basic_mode_e'(s.timerMode[1:0]); // RULE_21
    mode1 = basic_mode_e'(s.timerMode[5:4]); // RULE_21
    split0 = (mode0 == MODE_SPLIT);

    // Timer 0 low byte: reload or split, own controls
    src0 = s.timerMode[`BIT_T0_SOURCE] ? pinFall.t0CountPin : machineTick;
    count0 = src0 && gateOk(s.timerCtrl[`BIT_T0_RUN], s.timerMode[`BIT_T0_GATE], s.sync2.extIrq0Pin); // RULE_03
    ovf0 = 1'b0;
    if (count0 && (mode0 == MODE_RELOAD || split0)) begin
      if (s.t0LowCount == `COUNT_MAX8) begin
        ovf0 = 1'b1; // RULE_03
        next_s.t0LowCount = (mode0 == MODE_RELOAD) ? s.t0HighCount : 8'h00; // RULE_01
      end else begin
        next_s.t0LowCount = s.t0LowCount + 8'h01;
      end
    end

    // Timer 0 high byte in split mode: machine cycles on timer 1 run bit
    ovfHigh0 = 1'b0;
    if (split0 && machineTick && s.timerCtrl[`BIT_T1_RUN]) begin // RULE_04
      ovfHigh0 = (s.t0HighCount == `COUNT_MAX8); // RULE_04
      next_s.t0HighCount = s.t0HighCount + 8'h01;
    end

    // Timer 1: split mode holds; with timer 0 split it runs unless held
    src1 = s.timerMode[`BIT_T1_SOURCE] ? pinFall.t1CountPin : machineTick;
    count1 = src1 && (mode1 != MODE_SPLIT) // RULE_02
      && gateOk(split0 || s.timerCtrl[`BIT_T1_RUN], s.timerMode[`BIT_T1_GATE], s.sync2.extIrq1Pin); // RULE_05
    ovf1 = 1'b0;
    if (count1 && mode1 == MODE_RELOAD) begin
      if (s.t1LowCount == `COUNT_MAX8) begin
        ovf1 = 1'b1;
        next_s.t1LowCount = s.t1HighReload; // RULE_01
      end else begin
        next_s.t1LowCount = s.t1LowCount + 8'h01;
      end
    end

    // Timer 2 mode decode
    baudMode = s.timer2Control[`BIT_U1_RX_SEL] || s.timer2Control[`BIT_U1_TX_SEL]
      || s.powerControlReg[`BIT_U2_RX_SEL] || s.powerControlReg[`BIT_U2_TX_SEL]; // RULE_12
    captureMode = s.timer2Control[`BIT_T2_CAPTURE] && !baudMode; // RULE_11
    extEnable = s.timer2Control[`BIT_T2_EXT_EN];
    // Trigger level sets direction only in plain reload mode
    downCount = !captureMode && !baudMode && s.t2ModeRegister[`BIT_T2_DOWN_EN]
      && !s.sync2.t2TriggerPin; // RULE_20 RULE_19
    src2 = s.timer2Control[`BIT_T2_SOURCE] ? pinFall.t2CountPin : machineTick; // RULE_06
    t2Count = {s.t2CountHigh, s.t2CountLow};
    t2Reload = {s.t2CaptureHigh, s.t2CaptureLow};

    // Timer 2 counting
    ovf2 = 1'b0;
    if (s.timer2Control[`BIT_T2_RUN] && src2) begin // RULE_18
      if (downCount) begin
        // Underflow past the reload value wraps to all ones
        if (t2Count == t2Reload) begin
          ovf2 = 1'b1; // RULE_20
          {next_s.t2CountHigh, next_s.t2CountLow} = `COUNT_MAX16;
        end else begin
          {next_s.t2CountHigh, next_s.t2CountLow} = t2Count - 16'h0001;
        end
      end else if (t2Count == `COUNT_MAX16) begin
        ovf2 = 1'b1; // RULE_07
        // Capture mode wraps, reload and baud modes reload
        {next_s.t2CountHigh, next_s.t2CountLow} = captureMode ? 16'h0000 : t2Reload; // RULE_09 RULE_11
      end else begin
        {next_s.t2CountHigh, next_s.t2CountLow} = t2Count + 16'h0001; // RULE_19
      end
    end

    // Trigger pin events, ignored unless enabled
    trigEvent = pinFall.t2TriggerPin && extEnable; // RULE_16
    if (trigEvent) begin
      if (captureMode) begin
        // Captures the count as it stood before this edge's tick
        next_s.t2CaptureLow = s.t2CountLow; // RULE_08
        next_s.t2CaptureHigh = s.t2CountHigh; // RULE_08
      end else if (!baudMode && !s.t2ModeRegister[`BIT_T2_DOWN_EN]) begin
        {next_s.t2CountHigh, next_s.t2CountLow} = t2Reload; // RULE_10
      end
      // Baud mode: no capture or reload, flag only
    end

    // Register writes override counting in the same cycle
    if (regWrite) begin
      case (regAddr)
        `OFS_TIMER_CTRL: next_s.timerCtrl = regWdata;
        `OFS_TIMER_MODE: next_s.timerMode = regWdata;
        `OFS_T0_LOW: next_s.t0LowCount = regWdata;
        `OFS_T0_HIGH: next_s.t0HighCount = regWdata;
        `OFS_T1_LOW: next_s.t1LowCount = regWdata;
        `OFS_T1_HIGH: next_s.t1HighReload = regWdata;
        `OFS_T2_CONTROL: next_s.timer2Control = regWdata;
        `OFS_T2_MODE: next_s.t2ModeRegister = regWdata;
        `OFS_T2_COUNT_LOW: next_s.t2CountLow = regWdata;
        `OFS_T2_COUNT_HIGH: next_s.t2CountHigh = regWdata;
        `OFS_T2_CAP_LOW: next_s.t2CaptureLow = regWdata;
        `OFS_T2_CAP_HIGH: next_s.t2CaptureHigh = regWdata;
        `OFS_POWER_CONTROL: next_s.powerControlReg = regWdata;
        default: next_s.timerCtrl = next_s.timerCtrl; // Unmapped writes dropped
      endcase
    end

    // Basic timer flags: vector clears, overflow set wins
    if (ackT0) begin
      next_s.timerCtrl[`BIT_T0_FLAG] = 1'b0; // RULE_23
    end
    if (ackT1) begin
      next_s.timerCtrl[`BIT_T1_FLAG] = 1'b0; // RULE_23
    end
    if (ovf0) begin
      next_s.timerCtrl[`BIT_T0_FLAG] = 1'b1; // RULE_23
    end
    // With timer 0 split, timer 1 overflow raises no flag
    if (ovfHigh0 || (ovf1 && !split0)) begin
      next_s.timerCtrl[`BIT_T1_FLAG] = 1'b1; // RULE_04 RULE_05
    end

    // Timer 2 flags: only software clears them
    if (ovf2 && !baudMode) begin
      next_s.timer2Control[`BIT_T2_FLAG] = 1'b1; // RULE_12 RULE_17
    end
    if (trigEvent) begin
      next_s.timer2Control[`BIT_T2_EXT_FLAG] = 1'b1; // RULE_15 RULE_17
    end

    // Interrupt requests follow the flags
    next_s.irqT0 = next_s.timerCtrl[`BIT_T0_FLAG];
    next_s.irqT1 = next_s.timerCtrl[`BIT_T1_FLAG];
    next_s.irqT2 = next_s.timer2Control[`BIT_T2_FLAG]
      || next_s.timer2Control[`BIT_T2_EXT_FLAG]; // RULE_17

    // Baud pulses: timer 1 overflow still feeds ports in split mode
    next_s.baud.uart1Rx = s.timer2Control[`BIT_U1_RX_SEL] ? ovf2 : ovf1; // RULE_13
    next_s.baud.uart1Tx = s.timer2Control[`BIT_U1_TX_SEL] ? ovf2 : ovf1; // RULE_13
    next_s.baud.uart2Rx = s.powerControlReg[`BIT_U2_RX_SEL] ? ovf2 : ovf1; // RULE_14
    next_s.baud.uart2Tx = s.powerControlReg[`BIT_U2_TX_SEL] ? ovf2 : ovf1; // RULE_14

    // Read data stands only in the cycle after the strobe
    next_s.regRdata = regRead ? readReg(s, regAddr) : `RESET_BYTE;
  end

  // ======================================================
  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ======================================================
  // Outputs, all straight from flops
  assign regRdata = s.regRdata;
  assign irqT0 = s.irqT0;
  assign irqT1 = s.irqT1;
  assign irqT2 = s.irqT2;
  assign baud = s.baud;

endmodule : timer_autoreload_split_capture

// file: tb/timer_checker_sva.sv
// Concurrent checks on the timer block's top ports.
// Assumes it is bound to the top module, with MACHINE_DIV of 2 or more.
`timescale 1ns/1ns
`include "timer_params.svh"
module timer_checker
  import timer_pkg::*;
#(
  parameter int MACHINE_DIV = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  // Pins and core side
  input wire timer_pins_s pins,
  input wire logic ackT0,
  input wire logic ackT1,
  input wire logic irqT0,
  input wire logic irqT1,
  input wire logic irqT2,
  input wire baud_pulses_s baud
);
  // ==========================================================
  // Shadow of the timer 2 selects, rebuilt from port writes
  logic [7:0] t2Ctl;
  logic [1:0] u2Sel;
  logic wrT2;
  logic wrCtl;
  logic baudMode;
  assign wrT2 = regWrite && regAddr == `OFS_T2_CONTROL;
  assign wrCtl = regWrite && regAddr == `OFS_TIMER_CTRL;
  assign baudMode = (|t2Ctl[5:4]) || (|u2Sel);
  // Written values land one edge later, as in the block
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      t2Ctl <= 8'h00;
      u2Sel <= 2'h0;
    end else begin
      if (wrT2) begin
        t2Ctl <= regWdata;
      end
      if (regWrite && regAddr == `OFS_POWER_CONTROL) begin
        u2Sel <= regWdata[5:4];
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_read_idle: assert property (regRdata != 8'h00 |-> $past(regRead))
    else $error("read data outside its cycle");
  chk_mode_readback: assert property ((regWrite && regAddr == `OFS_T2_MODE)
    ##2 (regRead && regAddr == `OFS_T2_MODE) |=> regRdata == $past(regWdata, 3))
    else $error("mode register readback differs");
  chk_t0_flag_hold: assert property (irqT0 && !ackT0 && !wrCtl |=> irqT0)
    else $error("timer 0 request dropped without vector");
  chk_t1_flag_hold: assert property (irqT1 && !ackT1 && !wrCtl |=> irqT1)
    else $error("timer 1 request dropped without vector");
  chk_t2_flag_hold: assert property (irqT2 && !wrT2 |=> irqT2)
    else $error("timer 2 request cleared by hardware");
  chk_baud_single: assert property (baud != 4'h0 |=> baud == 4'h0)
    else $error("baud pulse longer than one cycle");
  chk_baud_no_flag: assert property (baudMode && !t2Ctl[3] && !irqT2 && !wrT2 |=> !irqT2)
    else $error("timer 2 flag raised in baud mode");
  chk_stop_quiet: assert property (!t2Ctl[2] && !t2Ctl[3] && !irqT2 && !wrT2 |=> !irqT2)
    else $error("stopped timer 2 raised a request");

  // Main scenarios reached
  cov_t2_req: cover property ($rose(irqT2));
  cov_t1_req: cover property ($rose(irqT1));
  cov_baud: cover property (baud != 4'h0);
endmodule : timer_checker

// file: tb/core_model.sv
// Model of the core and serial ports facing the timer block.
// Assumes requests are levels and baud pulses last one cycle.
`timescale 1ns/1ns
module core_model
  import timer_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Requests and baud clocks from the timer
  input wire logic irqT0,
  input wire logic irqT1,
  input wire baud_pulses_s baud,
  // Bench controls: vectoring on, and its latency
  input wire logic ackOn,
  input wire logic [3:0] ackDelay,
  // Vector acknowledges and baud pulse counts
  output logic ackT0,
  output logic ackT1,
  output logic [3:0][7:0] baudCount
);
  logic [3:0] wait0;
  logic [3:0] wait1;
  // Vector after a pending request has waited ackDelay cycles
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ackT0 <= 1'b0;
      ackT1 <= 1'b0;
      wait0 <= 4'h0;
      wait1 <= 4'h0;
      baudCount <= '0;
    end else begin
      ackT0 <= ackOn && irqT0 && !ackT0 && wait0 == ackDelay;
      ackT1 <= ackOn && irqT1 && !ackT1 && wait1 == ackDelay;
      wait0 <= (ackOn && irqT0 && wait0 != ackDelay) ? wait0 + 4'h1 : 4'h0;
      wait1 <= (ackOn && irqT1 && wait1 != ackDelay) ? wait1 + 4'h1 : 4'h0;
      // Serial ports only count their clocks; wraps are harmless
      for (int i = 0; i < 4; i++) begin
        baudCount[i] <= baudCount[i] + {7'h00, baud[i]};
      end
    end
  end
endmodule : core_model

// file: tb/timer_autoreload_split_capture_tb.sv
// Self-checking bench for the timer block, driven over its register port.
// Assumes the core model on the request side and MACHINE_DIV set to 2.
`timescale 1ns/1ns
`include "timer_params.svh"
module timer_autoreload_split_capture_tb
  import timer_pkg::*;
;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  timer_pins_s pins = 6'h3f;
  logic ackT0, ackT1, irqT0, irqT1, irqT2;
  logic ackOn = 1'b0;
  baud_pulses_s baud;
  logic [3:0][7:0] baudCount;
  logic [7:0] snap;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ==========================================================
  // Clock, timeout and instances
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  timer_autoreload_split_capture #(.MACHINE_DIV(2)) DUT (.clk_sys(clk_sys), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .pins(pins), .ackT0(ackT0), .ackT1(ackT1), .irqT0(irqT0),
    .irqT1(irqT1), .irqT2(irqT2), .baud(baud));
  core_model core (.clk_sys(clk_sys), .arst_n(arst_n), .irqT0(irqT0), .irqT1(irqT1),
    .baud(baud), .ackOn(ackOn), .ackDelay(4'h3), .ackT0(ackT0), .ackT1(ackT1),
    .baudCount(baudCount));

  // ==========================================================
  // Bus, wait and compare tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    // One idle edge so a following write never re-raises the strobe at once
    @(posedge clk_sys);
  endtask : wr
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Data stands one cycle only, so look mid-cycle
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    chk(regRdata, exp);
    @(posedge clk_sys);
  endtask : rc
  task automatic ci(input logic [2:0] exp);
    @(negedge clk_sys);
    chk({5'h00, irqT2, irqT1, irqT0}, {5'h00, exp});
    @(posedge clk_sys);
  endtask : ci
  task automatic wrap_up;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Scenarios
  initial begin
    wt(20);
    arst_n <= 1'b1;
    wt(1);
    for (int a = 0; a < 13; a++) rc(a[7:0], `RESET_BYTE);
    wr(8'h20, 8'h5a);
    rc(8'h20, 8'h00);
    wr(`OFS_T2_MODE, 8'ha4);
    rc(`OFS_T2_MODE, 8'ha4);
    wr(`OFS_T2_MODE, 8'h00);
    // Reload of ff every tick: a plain wrap would read 00
    for (int t = 0; t < 2; t++) begin
      wr(`OFS_T0_LOW + 8'(2 * t), 8'hff);
      wr(`OFS_T0_HIGH + 8'(2 * t), 8'hff);
      wr(`OFS_TIMER_MODE, t ? 8'h20 : 8'h02);
      wr(`OFS_TIMER_CTRL, t ? 8'h40 : 8'h10);
      wt(8);
      ci(t ? 3'b010 : 3'b001);
      wr(`OFS_TIMER_CTRL, t ? 8'h80 : 8'h20);
      rc(`OFS_T0_LOW + 8'(2 * t), 8'hff);
      rc(`OFS_T0_HIGH + 8'(2 * t), 8'hff);
      ackOn <= 1'b1;
      wt(10);
      ackOn <= 1'b0;
      ci(3'b000);
    end
    // Gate held low blocks counting, high lets it run
    pins.extIrq0Pin <= 1'b0;
    wr(`OFS_TIMER_MODE, 8'h0a);
    wr(`OFS_TIMER_CTRL, 8'h10);
    wt(10);
    ci(3'b000);
    pins.extIrq0Pin <= 1'b1;
    wt(10);
    ci(3'b001);
    wr(`OFS_TIMER_CTRL, 8'h20);
    wr(`OFS_TIMER_CTRL, 8'h00);
    // Timer 1 in its own split mode freezes
    wr(`OFS_T1_LOW, 8'h10);
    wr(`OFS_TIMER_MODE, 8'h30);
    wr(`OFS_TIMER_CTRL, 8'h40);
    wt(20);
    rc(`OFS_T1_LOW, 8'h10);
    // Timer 0 split: high byte runs on the timer 1 run bit
    wr(`OFS_TIMER_MODE, 8'h03);
    wt(10);
    ci(3'b010);
    wr(`OFS_TIMER_CTRL, 8'h80);
    rc(`OFS_T0_LOW, 8'hff);
    wr(`OFS_TIMER_CTRL, 8'h10);
    wt(6);
    ci(3'b001);
    wr(`OFS_TIMER_CTRL, 8'h20);
    wr(`OFS_TIMER_CTRL, 8'h00);
    // Timer 1 then only feeds the baud clocks, without a request
    wr(`OFS_T1_LOW, 8'hff);
    wr(`OFS_TIMER_MODE, 8'h23);
    snap = baudCount[1];
    wt(10);
    chk({7'h00, baudCount[1] != snap}, 8'h01);
    ci(3'b000);
    wr(`OFS_TIMER_MODE, 8'h33);
    wt(2);
    snap = baudCount[1];
    wt(10);
    chk(baudCount[1], snap);
    wr(`OFS_TIMER_MODE, 8'h00);
    // Timer 2 reload from ffff every tick
    for (int a = 8; a < 12; a++) wr(a[7:0], 8'hff);
    wr(`OFS_T2_CONTROL, 8'h04);
    wt(10);
    ci(3'b100);
    wr(`OFS_T2_CONTROL, 8'h80);
    rc(`OFS_T2_COUNT_LOW, 8'hff);
    rc(`OFS_T2_COUNT_HIGH, 8'hff);
    wr(`OFS_T2_CONTROL, 8'h00);
    ci(3'b000);
    // Capture mode ignores the down request on the trigger pin
    wr(`OFS_T2_MODE, 8'h01);
    pins.t2TriggerPin <= 1'b0;
    wr(`OFS_T2_CONTROL, 8'h05);
    wt(4);
    ci(3'b100);
    wr(`OFS_T2_CONTROL, 8'h81);
    rc(`OFS_T2_COUNT_HIGH, 8'h00);
    wr(`OFS_T2_MODE, 8'h00);
    // Trigger edge captures the count while stopped, and is ignored with external enable clear
    pins.t2TriggerPin <= 1'b1;
    wr(`OFS_T2_COUNT_LOW, 8'hcd);
    wr(`OFS_T2_COUNT_HIGH, 8'hab);
    wr(`OFS_T2_CONTROL, 8'h09);
    pins.t2TriggerPin <= 1'b0;
    wt(6);
    rc(`OFS_T2_CAP_LOW, 8'hcd);
    rc(`OFS_T2_CAP_HIGH, 8'hab);
    ci(3'b100);
    wr(`OFS_T2_CONTROL, 8'h01);
    pins.t2TriggerPin <= 1'b1;
    wr(`OFS_T2_COUNT_LOW, 8'h11);
    wt(4);
    pins.t2TriggerPin <= 1'b0;
    wt(6);
    rc(`OFS_T2_CAP_LOW, 8'hcd);
    ci(3'b000);
    // Trigger edge reloads in reload mode
    pins.t2TriggerPin <= 1'b1;
    wr(`OFS_T2_CAP_LOW, 8'h3c);
    wr(`OFS_T2_CAP_HIGH, 8'h4d);
    wr(`OFS_T2_CONTROL, 8'h08);
    pins.t2TriggerPin <= 1'b0;
    wt(6);
    rc(`OFS_T2_COUNT_LOW, 8'h3c);
    rc(`OFS_T2_COUNT_HIGH, 8'h4d);
    ci(3'b100);
    // In baud mode the edge only raises the external flag
    wr(`OFS_T2_CONTROL, 8'h18);
    pins.t2TriggerPin <= 1'b1;
    wr(`OFS_T2_CAP_LOW, 8'h77);
    wt(4);
    pins.t2TriggerPin <= 1'b0;
    wt(6);
    rc(`OFS_T2_COUNT_LOW, 8'h3c);
    rc(`OFS_T2_CAP_LOW, 8'h77);
    ci(3'b100);
    // Baud mode overrides capture select and raises no flag
    for (int a = 8; a < 12; a++) wr(a[7:0], 8'hff);
    wr(`OFS_T2_CONTROL, 8'h35);
    snap = baudCount[0];
    wt(10);
    wr(`OFS_T2_CONTROL, 8'h31);
    chk({7'h00, baudCount[0] != snap}, 8'h01);
    rc(`OFS_T2_COUNT_HIGH, 8'hff);
    ci(3'b000);
    wr(`OFS_POWER_CONTROL, 8'h30);
    wr(`OFS_T2_CONTROL, 8'h05);
    snap = baudCount[3];
    wt(10);
    wr(`OFS_T2_CONTROL, 8'h01);
    chk({7'h00, baudCount[3] != snap}, 8'h01);
    ci(3'b000);
    wr(`OFS_POWER_CONTROL, 8'h00);
    // Counter mode: only pin falling edges count
    wr(`OFS_T2_COUNT_LOW, 8'h00);
    wr(`OFS_T2_CONTROL, 8'h06);
    repeat (5) begin
      pins.t2CountPin <= 1'b0;
      wt(4);
      pins.t2CountPin <= 1'b1;
      wt(4);
    end
    wr(`OFS_T2_CONTROL, 8'h00);
    rc(`OFS_T2_COUNT_LOW, 8'h05);
    // Down count to the capture value reloads ffff
    wr(`OFS_T2_MODE, 8'h01);
    for (int a = 8; a < 12; a++) wr(a[7:0], (a == 8) ? 8'h05 : 8'h00);
    wr(`OFS_T2_CONTROL, 8'h04);
    wt(30);
    ci(3'b100);
    wr(`OFS_T2_CONTROL, 8'h80);
    rc(`OFS_T2_COUNT_HIGH, 8'hff);
    wrap_up();
  end
endmodule : timer_autoreload_split_capture_tb

bind timer_autoreload_split_capture timer_checker #(.MACHINE_DIV(MACHINE_DIV)) chk_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .pins(pins), .ackT0(ackT0),
  .ackT1(ackT1), .irqT0(irqT0), .irqT1(irqT1), .irqT2(irqT2), .baud(baud));
